/* autoneg_config_control.v */
// Purpose: negotiation configuration, advertisement, partner capture and status for one port
// Assumes: one 25 MHz clock, synchronous active-high reset, classic wishbone slave, 32-bit data
// Notes:   the flp burst physical layer is outside; it hands in received code words and link levels
`timescale 1ns/10ps
`include "autoneg_config_map.vh"

module autoneg_config_control #(
	parameter BREAK_CYCLES = `BREAK_LINK_MS * (`CLK_HZ / 1000)
) (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        cyc_i,
	input  wire        stb_i,
	input  wire        we_i,
	input  wire [7:0]  adr_i,
	input  wire [3:0]  sel_i,
	input  wire [31:0] dat_i,
	output wire [31:0] dat_o,
	output wire        ack_o,
	input  wire        negotiate_strap_i,
	input  wire        ability_select_hi_strap_i,
	input  wire        ability_select_lo_strap_i,
	input  wire        page_valid_i,
	input  wire [15:0] page_word_i,
	input  wire        link_good_i,
	input  wire        pd_link_100_i,
	input  wire        pd_link_10_i,
	output wire        tx_quiet_o,
	output wire        flp_enable_o,
	output wire [15:0] flp_word_o,
	output wire        speed_100_o,
	output wire        full_duplex_o
);

	localparam ST_IDLE       = 2'd0;
	localparam ST_BREAK      = 2'd1;
	localparam ST_FLP        = 2'd2;
	localparam ST_DONE       = 2'd3;

	localparam MODE_10_HALF  = 2'd0;
	localparam MODE_10_FULL  = 2'd1;
	localparam MODE_100_HALF = 2'd2;
	localparam MODE_100_FULL = 2'd3;

	// one selector for resolution and parallel detect keeps the priority in one place
	function [1:0] pick_mode;
		input [3:0] ab;
		begin
			if (ab[3]) begin
				pick_mode = MODE_100_FULL;
			end else if (ab[2]) begin
				pick_mode = MODE_100_HALF;
			end else if (ab[1]) begin
				pick_mode = MODE_10_FULL;
			end else begin
				pick_mode = MODE_10_HALF;
			end
		end
	endfunction

	// four ability bits out of the three straps; forced straps leave only the forced mode
	function [3:0] strap_advert;
		input [2:0] s;
		begin
			if (s[2]) begin
				case (s[1:0])
					2'b00:   strap_advert = 4'b0011;
					2'b01:   strap_advert = 4'b1100;
					2'b10:   strap_advert = 4'b0101;
					default: strap_advert = 4'b1111;
				endcase
			end else begin
				case (s[1:0])
					2'b00:   strap_advert = 4'b0001;
					2'b01:   strap_advert = 4'b0010;
					2'b10:   strap_advert = 4'b0100;
					default: strap_advert = 4'b1000;
				endcase
			end
		end
	endfunction

	// register index match, shared by the write and read paths
	function hit;
		input [5:0] idx_in;
		input [5:0] target;
		begin
			hit = (idx_in == target);
		end
	endfunction

	reg  [2:0]  strap_s1_q;
	reg  [2:0]  strap_s2_q;
	reg  [2:0]  strap_s3_q;
	reg         link_s1_q;
	reg         link_s2_q;
	reg         link_s3_q;
	reg         link_ok_q;
	reg         rst_seen_q;
	reg         strapped_q;
	reg  [15:0] control_q;
	reg  [3:0]  adv_q;
	reg  [15:0] partner_q;
	reg         complete_q;
	reg         partner_able_q;
	reg         page_rx_q;
	reg         pd_fault_q;
	reg  [1:0]  state_q;
	reg  [1:0]  state_d;
	reg  [31:0] timer_q;
	reg  [1:0]  mode_q;
	reg         ack_q;
	reg  [31:0] dat_q;
	reg  [31:0] dat_d;

	wire        req;
	wire        wr;
	wire        rd;
	wire [5:0]  idx;
	wire        neg_en;
	wire        restart;
	wire        capture_now;
	wire        start_neg;
	wire        break_done;
	wire        page_last;
	wire        pd_single;
	wire        pd_double;
	wire        pd_take;
	wire        flp_active;
	wire [3:0]  page_ab;
	wire [3:0]  page_common;
	wire [15:0] adv_word;
	wire [15:0] status_word;
	wire [15:0] expansion_word;
	wire [15:0] summary_word;

	assign req         = cyc_i & stb_i & ~ack_q;
	assign wr          = req & we_i & sel_i[0] & sel_i[1];
	assign rd          = req & ~we_i;
	assign idx         = adr_i[7:2];
	assign neg_en      = control_q[`CTL_NEG_EN_BIT];
	assign restart     = wr & hit(idx, `IDX_BASIC_CONTROL) & dat_i[`CTL_RESTART_BIT];
	assign capture_now = rst_seen_q & ~strapped_q & (strap_s2_q == strap_s3_q);
	assign start_neg   = restart | (neg_en & strapped_q & (state_q == ST_IDLE));
	assign break_done  = (timer_q == BREAK_CYCLES - 1);
	assign page_last   = page_valid_i & ~page_word_i[15];
	assign pd_single   = pd_link_100_i ^ pd_link_10_i;
	assign pd_double   = pd_link_100_i & pd_link_10_i;
	assign pd_take     = ~page_valid_i & pd_single;
	assign flp_active  = neg_en & (state_q == ST_FLP) & ~start_neg;
	assign adv_word    = {7'h00, adv_q, `ADV_SELECTOR};

	assign status_word    = `STS_ABILITY_CONST | {10'h000, complete_q, partner_q[13], 1'b0, link_ok_q, 2'b00};
	assign expansion_word = {11'h000, pd_fault_q, partner_q[15], 1'b0, page_rx_q, partner_able_q};
	assign summary_word   = {13'h0000, ~mode_q[0], ~mode_q[1], link_ok_q};

	// ability bit i of the advertisement lines up with code word bit 5+i
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_ability
			assign page_ab[gi]     = page_word_i[`ADV_10HD_BIT + gi];
			assign page_common[gi] = adv_q[gi] & page_ab[gi];
		end
	endgenerate

	// pins cross into the clock domain through three stages
	always @(posedge clk_i) begin
		strap_s1_q <= {negotiate_strap_i, ability_select_hi_strap_i, ability_select_lo_strap_i};
		strap_s2_q <= strap_s1_q;
		strap_s3_q <= strap_s2_q;
		link_s1_q  <= link_good_i;
		link_s2_q  <= link_s1_q;
		link_s3_q  <= link_s2_q;
	end

	// the filtered link holds its last value while the two late stages disagree
	always @(posedge clk_i) begin
		if (rst_i) begin
			link_ok_q <= 1'b0;
		end else if (link_s2_q == link_s3_q) begin
			link_ok_q <= link_s3_q;
		end
	end

	// straps are taken once after release; later activity on the shared pins is ignored
	always @(posedge clk_i) begin
		if (rst_i) begin
			rst_seen_q <= 1'b1;
			strapped_q <= 1'b0;
		end else if (capture_now) begin
			rst_seen_q <= 1'b0;
			strapped_q <= 1'b1;
		end
	end

	// ack answers one cycle after the request is taken and never twice in a row
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req;
		end
	end

	// restart self-clears: it is a strobe, never stored
	always @(posedge clk_i) begin
		if (rst_i) begin
			control_q <= 16'h0000;
		end else if (capture_now) begin
			control_q[`CTL_NEG_EN_BIT] <= strap_s3_q[2];
			control_q[`CTL_SPEED_BIT]  <= strap_s3_q[1];
			control_q[`CTL_DUPLEX_BIT] <= strap_s3_q[0];
		end else if (wr && hit(idx, `IDX_BASIC_CONTROL)) begin
			control_q <= {dat_i[15:10], 1'b0, dat_i[8:0]};
		end
	end

	// a written advertisement stays until the next reset reloads the straps
	always @(posedge clk_i) begin
		if (rst_i) begin
			adv_q <= 4'hf;
		end else if (capture_now) begin
			adv_q <= strap_advert(strap_s3_q);
		end else if (wr && hit(idx, `IDX_ADVERTISE)) begin
			adv_q <= {dat_i[`ADV_100FD_BIT], dat_i[`ADV_100HD_BIT],
				dat_i[`ADV_10FD_BIT], dat_i[`ADV_10HD_BIT]};
		end
	end

	// upper half always reads zero
	always @* begin
		dat_d = 32'h0000_0000;
		case (idx)
			`IDX_BASIC_CONTROL:  dat_d = {16'h0000, control_q};
			`IDX_BASIC_STATUS:   dat_d = {16'h0000, status_word};
			`IDX_ADVERTISE:      dat_d = {16'h0000, adv_word};
			`IDX_PARTNER:        dat_d = {16'h0000, partner_q};
			`IDX_EXPANSION:      dat_d = {16'h0000, expansion_word};
			`IDX_STATUS_SUMMARY: dat_d = {16'h0000, summary_word};
			default:             dat_d = 32'h0000_0000;
		endcase
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			dat_q <= 32'h0000_0000;
		end else if (rd) begin
			dat_q <= dat_d;
		end
	end

	// any state falls back to idle once negotiation is switched off, so forced bits rule again
	always @* begin
		state_d = state_q;
		if (start_neg) begin
			state_d = ST_BREAK;
		end else if (!neg_en) begin
			state_d = ST_IDLE;
		end else begin
			case (state_q)
				ST_BREAK: begin
					if (break_done) begin
						state_d = ST_FLP;
					end
				end
				ST_FLP: begin
					if (page_last || pd_take) begin
						state_d = ST_DONE;
					end
				end
				ST_DONE: begin
					state_d = ST_DONE;
				end
				default: begin
					state_d = ST_IDLE;
				end
			endcase
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// the break-link count restarts whenever the sequence is started again
	always @(posedge clk_i) begin
		if (rst_i) begin
			timer_q <= 32'h0000_0000;
		end else if (start_neg || state_q != ST_BREAK) begin
			timer_q <= 32'h0000_0000;
		end else if (!break_done) begin
			timer_q <= timer_q + 32'h0000_0001;
		end
	end

	// each page overwrites the last, so a next page replaces the base word
	always @(posedge clk_i) begin
		if (rst_i) begin
			partner_q      <= 16'h0000;
			partner_able_q <= 1'b0;
		end else if (flp_active) begin
			if (page_valid_i) begin
				partner_q      <= page_word_i;
				partner_able_q <= 1'b1;
			end else if (pd_single) begin
				partner_q      <= pd_link_100_i ? `PD_PARTNER_100 : `PD_PARTNER_10;
				partner_able_q <= 1'b0;
			end
		end
	end

	// completion and page flags are cleared by every new start
	always @(posedge clk_i) begin
		if (rst_i) begin
			page_rx_q  <= 1'b0;
			complete_q <= 1'b0;
		end else if (start_neg) begin
			page_rx_q  <= 1'b0;
			complete_q <= 1'b0;
		end else if (flp_active) begin
			if (page_valid_i) begin
				page_rx_q <= 1'b1;
			end
			if (page_last || pd_take) begin
				complete_q <= 1'b1;
			end
		end
	end

	// a fault raised in the same cycle as a read of the expansion register survives the read
	always @(posedge clk_i) begin
		if (rst_i) begin
			pd_fault_q <= 1'b0;
		end else if (flp_active && pd_double) begin
			pd_fault_q <= 1'b1;
		end else if (rd && hit(idx, `IDX_EXPANSION)) begin
			pd_fault_q <= 1'b0;
		end
	end

	// with negotiation on, the speed and duplex bits have no say in the mode
	always @(posedge clk_i) begin
		if (rst_i) begin
			mode_q <= MODE_10_HALF;
		end else if (!neg_en) begin
			mode_q <= {control_q[`CTL_SPEED_BIT], control_q[`CTL_DUPLEX_BIT]};
		end else if (flp_active && page_last) begin
			mode_q <= pick_mode(page_common);
		end else if (flp_active && pd_take) begin
			mode_q <= pick_mode({1'b0, pd_link_100_i, 1'b0, pd_link_10_i});
		end
	end

	assign dat_o         = dat_q;
	assign ack_o         = ack_q;
	assign tx_quiet_o    = neg_en & (state_q == ST_BREAK);
	assign flp_enable_o  = neg_en & (state_q == ST_FLP);
	assign flp_word_o    = adv_word;
	assign speed_100_o   = mode_q[1];
	assign full_duplex_o = mode_q[0];

endmodule // autoneg_config_control

/* autoneg_config_map.vh */
// Purpose: offsets, field positions, constant register words and timing counts for autoneg_config_control
// Assumes: 32-bit wishbone words, 16-bit registers in the low half
// Notes:   all offsets are register indices, not byte addresses; byte address is four times the index
`ifndef AUTONEG_CONFIG_MAP_VH
`define AUTONEG_CONFIG_MAP_VH

`define IDX_BASIC_CONTROL   6'h00
`define IDX_BASIC_STATUS    6'h01
`define IDX_ADVERTISE       6'h04
`define IDX_PARTNER         6'h05
`define IDX_EXPANSION       6'h06
`define IDX_STATUS_SUMMARY  6'h10

`define CTL_SPEED_BIT       13
`define CTL_NEG_EN_BIT      12
`define CTL_RESTART_BIT     9
`define CTL_DUPLEX_BIT      8

`define ADV_100FD_BIT       8
`define ADV_100HD_BIT       7
`define ADV_10FD_BIT        6
`define ADV_10HD_BIT        5
`define ADV_SELECTOR        5'h01

`define STS_ABILITY_CONST   16'h7849
`define PD_PARTNER_100      16'h0081
`define PD_PARTNER_10       16'h0021

`define BREAK_LINK_MS       1500
`define CLK_HZ              25000000

`endif

/* autoneg_config_properties.sv */
// Purpose: port-level timing properties of autoneg_config_control
// Assumes: break-link count shortened in simulation
// Notes:   only port relations; internal state is not visible
`timescale 1ns/10ps
module autoneg_config_checker (
	input wire        clk_i,
	input wire        rst_i,
	input wire        cyc_i,
	input wire        stb_i,
	input wire        we_i,
	input wire [7:0]  adr_i,
	input wire [3:0]  sel_i,
	input wire [31:0] dat_i,
	input wire [31:0] dat_o,
	input wire        ack_o,
	input wire        tx_quiet_o,
	input wire        flp_enable_o,
	input wire [15:0] flp_word_o,
	input wire        speed_100_o,
	input wire        full_duplex_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_rd(idx);
		cyc_i && stb_i && !ack_o && !we_i && adr_i[7:2] == idx;
	endsequence
	sequence s_restart;
		ack_o && we_i && sel_i[1:0] == 2'h3 && adr_i[7:2] == 6'h00 && dat_i[12] && dat_i[9];
	endsequence
	chk_ack_latency: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("late ack");
	chk_ack_pulse: assert property (ack_o |=> !ack_o) else $error("long ack");
	chk_status_const: assert property (s_rd(6'h01) |=> (dat_o & 32'hffffffcb) == 32'h00007849) else $error("ability");
	chk_summary_mode: assert property (s_rd(6'h10) ##1 dat_o[0] |-> dat_o[2:1] == {!full_duplex_o, !speed_100_o})
		else $error("summary");
	chk_advert_sent: assert property (s_rd(6'h04) |=> dat_o[15:0] == flp_word_o) else $error("advert");
	chk_quiet_no_flp: assert property (tx_quiet_o |-> !flp_enable_o) else $error("quiet flp");
	chk_restart_quiet: assert property (s_restart |-> ##[0:3] tx_quiet_o) else $error("no quiet");
	chk_quiet_holds: assert property ($rose(tx_quiet_o) |-> tx_quiet_o[*8]) else $error("short quiet");
endmodule // autoneg_config_checker
bind autoneg_config_control autoneg_config_checker chk (.*);

/* link_partner_model.sv */
// Purpose: far-end partner handing base pages
// Assumes: one-cycle go pulse per page
// Notes:   idle word toggles so a stale capture shows
`timescale 1ns/10ps
module link_partner_model (
	input  wire        clk_i,
	input  wire        go_i,
	input  wire [15:0] word_i,
	output reg         page_valid_o = 0,
	output reg  [15:0] page_word_o = 16'h5555
);
	always @(posedge clk_i) begin
		page_valid_o <= go_i;
		page_word_o  <= go_i ? word_i : ~page_word_o;
	end
endmodule // link_partner_model

/* testbench.sv */
// Purpose: self-checking bench for autoneg_config_control
// Assumes: break-link count of 20 cycles
// Notes:   negotiation waits are generous, page timing is loose
`timescale 1ns/10ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin failures++; $display("Error %s exp %h got %h", n, e, g); end end
module testbench;
	logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, pv, quiet, flp, spd, fdx;
	logic        neg = 1, s_hi = 1, s_lo = 1, go = 0, link = 0, pd100 = 0, pd10 = 0;
	logic [7:0]  adr = 0;
	logic [3:0]  sel = 0;
	logic [15:0] word = 0, pw, fword;
	logic [31:0] wdat = 0, rdat, r;
	int          failures = 0, check_count = 0, cycles = 0;
	always #20 clk = ~clk;
	link_partner_model partner (.clk_i(clk), .go_i(go), .word_i(word), .page_valid_o(pv), .page_word_o(pw));
	autoneg_config_control #(.BREAK_CYCLES(20)) dut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .negotiate_strap_i(neg),
		.ability_select_hi_strap_i(s_hi), .ability_select_lo_strap_i(s_lo), .page_valid_i(pv), .page_word_i(pw),
		.link_good_i(link), .pd_link_100_i(pd100), .pd_link_10_i(pd10), .tx_quiet_o(quiet),
		.flp_enable_o(flp), .flp_word_o(fword), .speed_100_o(spd), .full_duplex_o(fdx));
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		{cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hf};
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		r = rdat;
		{cyc, stb} <= 2'b00;
		@(posedge clk);
	endtask
	task automatic do_reset(input logic [2:0] s);
		{neg, s_hi, s_lo, rst} <= {s, 1'b1};
		repeat (3) @(posedge clk);
		rst <= 0;
		repeat (6) @(posedge clk);
	endtask
	task automatic t_straps;
		logic [15:0] tbl = 16'hf5c3;
		logic [3:0]  e;
		for (int c = 0; c < 8; c++) begin
			do_reset(c[2:0]);
			wb(0, 8'h10, 0);
			e = c[2] ? tbl[c[1:0]*4 +: 4] : 4'b0001 << c[1:0];
			`CHK("advert", e, r[8:5])
			`CHK("flp word", e, fword[8:5])
			if (!c[2]) `CHK("forced", c[1:0], {spd, fdx})
		end
	endtask
	task automatic t_persist;
		wb(1, 8'h10, 32'h0061);
		{neg, s_hi, s_lo} <= 3'b000;
		repeat (10) @(posedge clk);
		wb(0, 8'h10, 0);
		`CHK("advert kept", 16'h0061, r[15:0])
		do_reset(3'b111);
		wb(0, 8'h10, 0);
		`CHK("advert reload", 4'hf, r[8:5])
	endtask
	task automatic t_ctl_forced;
		for (int k = 0; k < 4; k++) begin
			wb(1, 8'h00, {18'h0, k[1], 4'h0, k[0], 8'h00});
			repeat (3) @(posedge clk);
			`CHK("ctl mode", k[1:0], {spd, fdx})
		end
	endtask
	task automatic t_negotiate;
		logic [15:0] pg [4] = '{16'h0021, 16'h0061, 16'h00a1, 16'h01e1};
		for (int k = 0; k < 5; k++) begin
			link <= 0;
			// last pass drops local 100 full so the answer falls one step
			if (k == 4) wb(1, 8'h10, 32'h00e1);
			wb(1, 8'h00, 32'h3300);
			repeat (40) @(posedge clk);
			{go, word, link} <= {1'b1, pg[k < 4 ? k : 3], 1'b1};
			@(posedge clk);
			go <= 0;
			repeat (10) @(posedge clk);
			`CHK("resolved", k < 4 ? k[1:0] : 2'b10, {spd, fdx})
			wb(0, 8'h14, 0);
			`CHK("partner", pg[k < 4 ? k : 3], r[15:0])
		end
	endtask
	task automatic t_pd;
		for (int k = 0; k < 2; k++) begin
			{link, pd100, pd10} <= 3'b000;
			wb(1, 8'h00, 32'h1200);
			repeat (40) @(posedge clk);
			{link, pd100, pd10} <= {1'b1, !k[0], k[0]};
			repeat (60) @(posedge clk);
			wb(0, 8'h14, 0);
			`CHK("pd partner", k ? 16'h0021 : 16'h0081, r[15:0])
			wb(0, 8'h18, 0);
			`CHK("partner able", 1'b0, r[0])
		end
	endtask
	task automatic t_status;
		wb(0, 8'h04, 0);
		`CHK("ability", 32'h7849, r & 32'hffffffcb)
		`CHK("done link", 2'b11, {r[5], r[2]})
		wb(0, 8'h40, 0);
		`CHK("summary", 3'b111, r[2:0])
		wb(0, 8'hfc, 0);
		`CHK("unmapped", 32'h0, r)
	endtask
	task automatic finish_test;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ceiling well above the several hundred cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			finish_test();
		end
	end
	initial begin
		do_reset(3'b111);
		t_straps();
		t_persist();
		t_ctl_forced();
		t_negotiate();
		t_pd();
		t_status();
		finish_test();
	end
endmodule // testbench
